// ---- include/bcfu_consts.svh ----
// constants of the binary compare flag unit: function codes, offsets,
// reset values and timing counts; assumes inclusion by bare name
`ifndef BCFU_CONSTS_SVH
`define BCFU_CONSTS_SVH

// ----------------------------------------------------------------------
// function codes of the compare operations
// ----------------------------------------------------------------------
`define BCFU_FUNC_UWORD  7'h14
`define BCFU_FUNC_UDBL   7'h3C
`define BCFU_FUNC_SWORD  7'h72
`define BCFU_FUNC_SDBL   7'h73

// ----------------------------------------------------------------------
// wishbone byte offsets
// ----------------------------------------------------------------------
`define BCFU_OFS_FLAGS   16'h0000
`define BCFU_OFS_STATUS  16'h0004
`define BCFU_OFS_SCAN    16'h0008
`define BCFU_MEM_BIT     15

// ----------------------------------------------------------------------
// reset values, defaults and timing counts
// ----------------------------------------------------------------------
`define BCFU_FLAGS_RST   8'h00
`define BCFU_ADDR_W      8
`define BCFU_INPUT_ADDR  16'h0000
`define BCFU_FETCH_STEPS 3'h4
`define BCFU_CMP_LAT     7

`endif

// ---- include/bcfu_pkg.sv ----
// types of the binary compare flag unit
// assumes bcfu_consts.svh is on the include path
package bcfu_pkg;
`include "bcfu_consts.svh"

    // command from the instruction sequencer
    typedef struct packed {
        logic [6:0]  func;     // function code
        logic        imm;      // immediate-refresh variant
        logic        s1_const; // s1 is a constant, else a word address
        logic        s2_const;
        logic [31:0] s1;
        logic [31:0] s2;
    } bcfu_cmd_t;

    // auxiliary arithmetic flags
    typedef struct packed {
        logic er;
        logic n;
        logic gt;
        logic ge;
        logic eq;
        logic le;
        logic lt;
        logic ne;
    } bcfu_flags_t;

    typedef enum logic [1:0] {E_IDLE, E_FETCH, E_CMP} bcfu_eng_t;
    typedef enum logic [1:0] {B_IDLE, B_MEMRD} bcfu_bus_t;
endpackage

// ---- hdl/bcfu_word_mem.sv ----
// single-port word memory holding the operand data area
// assumes one clock; read data come out of a register
module bcfu_word_mem #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    input  wire logic                clk_i,
    input  wire logic                en_i,
    input  wire logic [DATA_W/8-1:0] we_i,
    input  wire logic [ADDR_W-1:0]   addr_i,
    input  wire logic [DATA_W-1:0]   wdata_i,
    output logic      [DATA_W-1:0]   rdata_o
);
    logic [DATA_W-1:0] mem_reg [2**ADDR_W];

    if (DATA_W % 8 != 0 || ADDR_W < 1 || ADDR_W > 15) begin : g_chk
        $error("bcfu_word_mem: unsupported width");
    end

    // ------------------------------------------------------------------
    // byte-lane write and registered read
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            for (int b = 0; b < DATA_W / 8; b++) begin
                if (we_i[b]) begin
                    mem_reg[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
                end
            end
            rdata_o <= mem_reg[addr_i];
        end
    end
endmodule

// ---- hdl/bcfu_top.sv ----
// binary compare flag unit: compares two operands and sets the six
// relational arithmetic flags; word data area on classic wishbone
// assumes commands come from logic on clk_i, input pins are async
`include "bcfu_consts.svh"
module bcfu_top
    import bcfu_pkg::*;
#(
    parameter int          ADDR_W     = `BCFU_ADDR_W,
    parameter logic [15:0] INPUT_ADDR = `BCFU_INPUT_ADDR
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cmd_valid_i,
    input  wire bcfu_pkg::bcfu_cmd_t  cmd_i,
    output logic                      cmd_ready_o,
    output logic                      done_o,
    output bcfu_pkg::bcfu_flags_t     flags_o,
    input  wire logic [15:0]          in_pins_i,
    input  wire logic                 scan_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [15:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o
);
    import bcfu_pkg::*;

    // word index sits in bus address bits [ADDR_W+1:2], below the memory select bit
    if (ADDR_W < 1 || ADDR_W > 13 || INPUT_ADDR >= 16'(2**ADDR_W)) begin : g_chk
        $error("bcfu_top: ADDR_W or INPUT_ADDR out of range");
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    bcfu_eng_t         e_state_reg, e_state_next;
    bcfu_bus_t         b_state_reg, b_state_next;
    bcfu_cmd_t         cmd_reg, cmd_next;
    bcfu_flags_t       flags_reg, flags_next;
    logic [3:0][15:0]  word_reg, word_next;
    logic [2:0]        step_reg, step_next;
    logic              pend_vld_reg, pend_vld_next;
    logic              pend_inp_reg, pend_inp_next;
    logic [1:0]        pend_idx_reg, pend_idx_next;
    logic              ready_reg, ready_next;
    logic              done_reg, done_next;
    logic              bad_reg, bad_next;
    logic              ack_reg, ack_next;
    logic [31:0]       dat_reg, dat_next;
    logic [15:0]       sync1_reg, sync2_reg, scan_reg;
    logic              mem_en;
    logic [1:0]        mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [15:0]       mem_wdata, mem_rdata;
    logic              is_dbl, is_sgn, opnd_const, need, is_input, eng_rd;
    logic [15:0]       word_addr;
    logic              accept, cmd_ok, bus_req, bus_mem, mem_free, flag_wr;
    logic [31:0]       a32, b32;
    logic              res_gt, res_eq, res_lt;

    // ------------------------------------------------------------------
    // input terminal word: two-flop synchroniser and scanned copy
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            scan_reg  <= 16'h0000;
        end else begin
            sync1_reg <= in_pins_i;
            sync2_reg <= sync1_reg;
            if (scan_i) begin
                scan_reg <= sync2_reg; // regular input refresh
            end
        end
    end

    // ------------------------------------------------------------------
    // operand decode for the current fetch step
    // ------------------------------------------------------------------
    assign is_dbl = cmd_reg.func == `BCFU_FUNC_UDBL || cmd_reg.func == `BCFU_FUNC_SDBL;
    assign is_sgn = cmd_reg.func == `BCFU_FUNC_SWORD || cmd_reg.func == `BCFU_FUNC_SDBL;
    assign opnd_const = step_reg[1] ? cmd_reg.s2_const : cmd_reg.s1_const;
    // low word at the given address, high word at the next one
    assign word_addr = (step_reg[1] ? cmd_reg.s2[15:0] : cmd_reg.s1[15:0])
                       + {15'h0000, step_reg[0]};
    assign need = step_reg < `BCFU_FETCH_STEPS && !opnd_const
                  && (is_dbl || !step_reg[0]);
    assign is_input = word_addr == INPUT_ADDR;
    assign eng_rd   = e_state_reg == E_FETCH && need && !is_input;
    assign accept   = cmd_valid_i && ready_reg;
    // immediate variant only for word compares
    assign cmd_ok = (cmd_i.func == `BCFU_FUNC_UWORD || cmd_i.func == `BCFU_FUNC_SWORD)
                    || ((cmd_i.func == `BCFU_FUNC_UDBL || cmd_i.func == `BCFU_FUNC_SDBL)
                        && !cmd_i.imm);

    // ------------------------------------------------------------------
    // full-width comparison, signed or unsigned
    // ------------------------------------------------------------------
    always_comb begin
        if (is_dbl) begin
            a32 = {word_reg[1], word_reg[0]};
            b32 = {word_reg[3], word_reg[2]};
        end else if (is_sgn) begin
            a32 = {{16{word_reg[0][15]}}, word_reg[0]};
            b32 = {{16{word_reg[2][15]}}, word_reg[2]};
        end else begin
            a32 = {16'h0000, word_reg[0]};
            b32 = {16'h0000, word_reg[2]};
        end
        res_eq = a32 == b32;
        if (is_sgn) begin
            res_lt = $signed(a32) < $signed(b32);
        end else begin
            res_lt = a32 < b32;
        end
        res_gt = !res_eq && !res_lt;
    end

    // ------------------------------------------------------------------
    // compare engine: next state
    // ------------------------------------------------------------------
    always_comb begin
        e_state_next  = e_state_reg;
        cmd_next      = cmd_reg;
        word_next     = word_reg;
        step_next     = step_reg;
        pend_vld_next = 1'b0;
        pend_inp_next = 1'b0;
        pend_idx_next = step_reg[1:0];
        done_next     = 1'b0;
        bad_next      = bad_reg;
        flags_next    = flags_reg;
        // software write of the flag area
        if (flag_wr) begin
            flags_next = wb_dat_i[7:0];
        end
        // capture the word read in the previous step
        if (pend_vld_reg) begin
            if (!pend_inp_reg) begin
                word_next[pend_idx_reg] = mem_rdata;
            end else if (cmd_reg.imm) begin
                word_next[pend_idx_reg] = sync2_reg; // fresh input sample
            end else begin
                word_next[pend_idx_reg] = scan_reg;
            end
        end
        case (e_state_reg)
            E_IDLE: begin
                if (accept) begin
                    cmd_next  = cmd_i;
                    word_next = {cmd_i.s2[31:16], cmd_i.s2[15:0],
                                 cmd_i.s1[31:16], cmd_i.s1[15:0]};
                    step_next = 3'h0;
                    bad_next  = !cmd_ok;
                    if (cmd_ok) begin
                        e_state_next = E_FETCH;
                    end else begin
                        done_next = 1'b1; // refused: flags untouched
                    end
                end
            end
            E_FETCH: begin
                pend_vld_next = need;
                pend_inp_next = is_input;
                step_next     = step_reg + 3'h1;
                if (step_reg == `BCFU_FETCH_STEPS) begin
                    e_state_next = E_CMP;
                end
            end
            E_CMP: begin
                // hardware update of the six relational flags wins over a same-cycle software write
                flags_next.gt = res_gt;
                flags_next.ge = res_gt || res_eq;
                flags_next.eq = res_eq;
                flags_next.le = res_lt || res_eq;
                flags_next.lt = res_lt;
                flags_next.ne = !res_eq;
                // er and n keep their value, or take a same-cycle software write
                done_next    = 1'b1;
                e_state_next = E_IDLE;
            end
            default: begin
                e_state_next = E_IDLE;
            end
        endcase
        ready_next = e_state_next == E_IDLE;
    end

    // compare engine: registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            e_state_reg  <= E_IDLE;
            cmd_reg      <= '0;
            word_reg     <= '0;
            step_reg     <= 3'h0;
            pend_vld_reg <= 1'b0;
            pend_inp_reg <= 1'b0;
            pend_idx_reg <= 2'h0;
            ready_reg    <= 1'b1;
            done_reg     <= 1'b0;
            bad_reg      <= 1'b0;
            flags_reg    <= `BCFU_FLAGS_RST;
        end else begin
            e_state_reg  <= e_state_next;
            cmd_reg      <= cmd_next;
            word_reg     <= word_next;
            step_reg     <= step_next;
            pend_vld_reg <= pend_vld_next;
            pend_inp_reg <= pend_inp_next;
            pend_idx_reg <= pend_idx_next;
            ready_reg    <= ready_next;
            done_reg     <= done_next;
            bad_reg      <= bad_next;
            flags_reg    <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave: next state
    // ------------------------------------------------------------------
    assign bus_req  = wb_cyc_i && wb_stb_i && !ack_reg && b_state_reg == B_IDLE;
    assign bus_mem  = wb_adr_i[`BCFU_MEM_BIT];
    assign mem_free = e_state_reg == E_IDLE && !cmd_valid_i;
    assign flag_wr  = bus_req && !bus_mem && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == `BCFU_OFS_FLAGS;

    always_comb begin
        b_state_next = b_state_reg;
        ack_next     = 1'b0;
        dat_next     = 32'h0000_0000;
        case (b_state_reg)
            B_IDLE: begin
                if (bus_req && !bus_mem) begin
                    ack_next = 1'b1; // unmapped reads zero, writes dropped
                    case (wb_adr_i)
                        `BCFU_OFS_FLAGS:  dat_next = {24'h00_0000, flags_reg};
                        `BCFU_OFS_STATUS: dat_next = {30'h0000_0000, bad_reg, !ready_reg};
                        `BCFU_OFS_SCAN:   dat_next = {16'h0000, scan_reg};
                        default:          dat_next = 32'h0000_0000;
                    endcase
                end else if (bus_req && mem_free) begin
                    if (wb_we_i) begin
                        ack_next = 1'b1;
                    end else begin
                        b_state_next = B_MEMRD;
                    end
                end
            end
            B_MEMRD: begin
                ack_next     = 1'b1;
                dat_next     = {16'h0000, mem_rdata};
                b_state_next = B_IDLE;
            end
            default: begin
                b_state_next = B_IDLE;
            end
        endcase
    end

    // wishbone slave: registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b_state_reg <= B_IDLE;
            ack_reg     <= 1'b0;
            dat_reg     <= 32'h0000_0000;
        end else begin
            b_state_reg <= b_state_next;
            ack_reg     <= ack_next;
            dat_reg     <= dat_next;
        end
    end

    // ------------------------------------------------------------------
    // memory port: engine reads only, bus when the engine is idle
    // ------------------------------------------------------------------
    always_comb begin
        mem_en    = 1'b0;
        mem_we    = 2'b00;
        mem_addr  = word_addr[ADDR_W-1:0];
        mem_wdata = wb_dat_i[15:0];
        if (eng_rd) begin
            mem_en = 1'b1; // no write path from the engine
        end else if (bus_req && bus_mem && mem_free) begin
            mem_en   = 1'b1;
            mem_we   = wb_we_i ? wb_sel_i[1:0] : 2'b00;
            mem_addr = wb_adr_i[ADDR_W+1:2];
        end
    end

    bcfu_word_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (16)
    ) u_mem (
        .clk_i   (clk_i),
        .en_i    (mem_en),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mem_wdata),
        .rdata_o (mem_rdata)
    );

    assign cmd_ready_o = ready_reg;
    assign done_o      = done_reg;
    assign flags_o     = flags_reg;
    assign wb_ack_o    = ack_reg;
    assign wb_dat_o    = dat_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_result_onehot: assert property (done_o && !bad_reg |->
        $onehot({flags_o.gt, flags_o.eq, flags_o.lt})
        && flags_o.ge == (flags_o.gt || flags_o.eq)
        && flags_o.le == (flags_o.lt || flags_o.eq) && flags_o.ne == !flags_o.eq)
        else $error("flag pattern inconsistent");
    a_uword_order: assert property (done_o && !bad_reg
        && cmd_reg.func == `BCFU_FUNC_UWORD |-> flags_o.lt == (word_reg[0] < word_reg[2]))
        else $error("unsigned word order wrong");
    a_udbl_order: assert property (done_o && !bad_reg
        && cmd_reg.func == `BCFU_FUNC_UDBL
        |-> flags_o.gt == ({word_reg[1], word_reg[0]} > {word_reg[3], word_reg[2]}))
        else $error("unsigned double order wrong");
    a_sword_order: assert property (done_o && !bad_reg
        && cmd_reg.func == `BCFU_FUNC_SWORD
        |-> flags_o.lt == ($signed(word_reg[0]) < $signed(word_reg[2])))
        else $error("signed word order wrong");
    a_sdbl_order: assert property (done_o && !bad_reg
        && cmd_reg.func == `BCFU_FUNC_SDBL
        |-> flags_o.lt == ($signed({word_reg[1], word_reg[0]})
                           < $signed({word_reg[3], word_reg[2]})))
        else $error("signed double order wrong");
    a_er_n_kept: assert property (done_o && !$past(flag_wr)
        |-> flags_o.er == $past(flags_o.er) && flags_o.n == $past(flags_o.n))
        else $error("error or negative flag changed");
    a_no_dest_write: assert property (e_state_reg != E_IDLE |-> mem_we == 2'b00)
        else $error("memory written during compare");
    a_cmp_latency: assert property (accept && cmd_ok |=>
        !done_o [*6] ##1 done_o)
        else $error("compare latency not seven cycles");
    a_dbl_fetch: assert property (e_state_reg == E_FETCH && is_dbl
        && step_reg == 3'h1 && !cmd_reg.s1_const |-> word_addr == cmd_reg.s1[15:0] + 16'h0001)
        else $error("high word not at next address");
    a_imm_fresh: assert property (pend_vld_reg && pend_inp_reg && cmd_reg.imm
        |=> word_reg[$past(pend_idx_reg)] == $past(sync2_reg))
        else $error("immediate compare used stale input");

    c_uword: cover property (accept && cmd_i.func == `BCFU_FUNC_UWORD ##7 done_o);
    c_sdbl_lt: cover property (done_o && cmd_reg.func == `BCFU_FUNC_SDBL && flags_o.lt);
    c_imm_input: cover property (pend_vld_reg && pend_inp_reg && cmd_reg.imm);
    c_bad_cmd: cover property (done_o && bad_reg);
endmodule

// ---- bench/bcfu_seq_model.sv ----
// sequencer model: issues one compare command and collects its flags
// assumes the unit's valid/ready command port on one rising-edge clock
module bcfu_seq_model (
    input  wire logic                  clk_i,
    input  wire logic                  cmd_ready_i,
    input  wire logic                  done_i,
    input  wire bcfu_pkg::bcfu_flags_t flags_i,
    output logic                       cmd_valid_o,
    output bcfu_pkg::bcfu_cmd_t        cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import bcfu_pkg::*;

    // idle port at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end

    // hold the command until the taking edge, then wait for done
    task automatic issue(input bcfu_cmd_t c, output bcfu_flags_t f, output int lat);
        lat = 0;
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
        cmd_valid_o <= 1'b0;
        cmd_o       <= ~c; // released fields show no stale command
        do begin
            @(posedge clk_i);
            lat++;
        end while (done_i !== 1'b1 && lat < 50);
        f = flags_i;
    endtask
endmodule

// ---- bench/bcfu_top_tb_top.sv ----
// self-checking bench of the binary compare flag unit
// assumes bcfu_pkg and bcfu_seq_model are compiled before it
`include "bcfu_consts.svh"
module bcfu_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bcfu_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [7:0] GT = 8'h31;
    localparam logic [7:0] EQ = 8'h1C;
    localparam logic [7:0] LT = 8'h07;
    localparam logic [7:0] KP = 8'hC0;
    localparam int         LAT = `BCFU_CMP_LAT;
    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic        scan_i    = 1'b0;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [15:0] wb_adr_i  = 16'h0000;
    logic [3:0]  wb_sel_i  = 4'hF;
    logic [31:0] wb_dat_i  = 32'h0000_0000;
    logic [15:0] in_pins_i = 16'h0000;
    logic        cmd_valid_i, cmd_ready_o, done_o, wb_ack_o;
    logic [31:0] wb_dat_o;
    bcfu_cmd_t   cmd_i;
    bcfu_flags_t flags_o;
    int          fail_count = 0;
    int          checked    = 0;

    bcfu_top #(.ADDR_W(`BCFU_ADDR_W), .INPUT_ADDR(`BCFU_INPUT_ADDR)) bcfu_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .flags_o(flags_o),
        .in_pins_i(in_pins_i), .scan_i(scan_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));

    bcfu_seq_model bcfu_seq_model_i (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o),
        .done_i(done_o), .flags_i(flags_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask

    // classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        chk(wb_ack_o, 1, "wb ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic cmp(input logic [6:0] fn, input int im, input int c1, input int c2,
                       input logic [31:0] a, input logic [31:0] b, input logic [7:0] ef,
                       input int el, input string m);
        bcfu_flags_t f;
        int lat;
        bcfu_seq_model_i.issue({fn, im[0], c1[0], c2[0], a, b}, f, lat);
        chk(f, ef, m);
        chk(lat, el, "latency");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_unsigned();
        logic [31:0] q;
        logic [15:0] w [4] = '{16'h5678, 16'h1234, 16'hEF12, 16'hABCD};
        chk(flags_o, `BCFU_FLAGS_RST, "reset flags");
        wb(1'b0, 16'h0100, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        for (int i = 0; i < 4; i++) wb(1'b1, 16'h8000 + 16'(4 * (16 + i)), {16'h0, w[i]}, q);
        wb(1'b1, `BCFU_OFS_FLAGS, 32'h0000_00C0, q); // error and negative preset
        cmp(`BCFU_FUNC_UWORD, 0, 1, 1, 5, 3, KP | GT, LAT, "u gt");
        cmp(`BCFU_FUNC_UWORD, 0, 1, 1, 32'h1_7777, 32'h7777, KP | EQ, LAT, "u eq");
        cmp(`BCFU_FUNC_UWORD, 0, 1, 1, 1, 16'hFFFF, KP | LT, LAT, "u lt");
        cmp(`BCFU_FUNC_UDBL, 0, 0, 0, 16, 18, KP | LT, LAT, "ud lt");
        cmp(`BCFU_FUNC_UDBL, 0, 0, 0, 18, 16, KP | GT, LAT, "ud gt");
        cmp(`BCFU_FUNC_UDBL, 0, 1, 1, 32'h1_0000, 32'hFFFF, KP | GT, LAT, "ud wide");
        cmp(`BCFU_FUNC_UDBL, 0, 0, 1, 16, 32'h1234_5678, KP | EQ, LAT, "ud eq");
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 16'h8000 + 16'(4 * (16 + i)), 32'h0, q);
            chk(q, {16'h0, w[i]}, "word kept");
        end
        $display("test unsigned done");
    endtask

    task automatic t_signed();
        logic [31:0] q;
        wb(1'b1, `BCFU_OFS_FLAGS, 32'h0, q);
        cmp(`BCFU_FUNC_SWORD, 0, 1, 1, 1, 16'hFFFF, GT, LAT, "s gt");
        cmp(`BCFU_FUNC_SWORD, 0, 1, 1, 16'h8000, 16'h7FFF, LT, LAT, "s lt");
        cmp(`BCFU_FUNC_SWORD, 0, 1, 1, 16'h8000, 16'h8000, EQ, LAT, "s eq");
        cmp(`BCFU_FUNC_SDBL, 0, 1, 1, 32'hFFFF_FFFF, 1, LT, LAT, "sd lt");
        cmp(`BCFU_FUNC_SDBL, 0, 1, 1, 1, 32'h8000_0000, GT, LAT, "sd gt");
        cmp(`BCFU_FUNC_SDBL, 0, 0, 0, 16, 18, GT, LAT, "sd words");
        $display("test signed done");
    endtask

    task automatic t_immediate();
        logic [31:0] q;
        in_pins_i <= 16'h1234;
        repeat (3) @(posedge clk_i);
        scan_i <= 1'b1;
        @(posedge clk_i);
        scan_i    <= 1'b0;
        in_pins_i <= 16'h9000;
        repeat (4) @(posedge clk_i);
        wb(1'b0, `BCFU_OFS_SCAN, 32'h0, q);
        chk(q, 32'h1234, "scan copy");
        cmp(`BCFU_FUNC_UWORD, 1, 0, 1, 0, 16'h9000, EQ, LAT, "imm fresh");
        cmp(`BCFU_FUNC_UWORD, 0, 0, 1, 0, 16'h9000, LT, LAT, "scanned");
        cmp(`BCFU_FUNC_SWORD, 1, 0, 1, 0, 1, LT, LAT, "s imm");
        $display("test immediate done");
    endtask

    task automatic t_refused();
        logic [31:0] q;
        cmp(7'h00, 0, 1, 1, 1, 2, LT, 1, "bad func");
        cmp(`BCFU_FUNC_SDBL, 1, 1, 1, 1, 2, LT, 1, "sd imm");
        wb(1'b0, `BCFU_OFS_STATUS, 32'h0, q);
        chk(q, 32'h2, "status bad");
        cmp(`BCFU_FUNC_UWORD, 0, 1, 1, 2, 2, EQ, LAT, "after bad");
        wb(1'b0, `BCFU_OFS_FLAGS, 32'h0, q);
        chk(q, {24'h0, EQ}, "flags reg");
        wb(1'b0, `BCFU_OFS_STATUS, 32'h0, q);
        chk(q, 32'h0, "status clear");
        $display("test refused done");
    endtask

    // ------------------------------------------------------------
    // clock, sequence, verdict
    // ------------------------------------------------------------
    always #4 clk_i = ~clk_i;

    task automatic give_verdict();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_unsigned();
        t_signed();
        t_immediate();
        t_refused();
        give_verdict();
    end

    // watchdog against a hung handshake
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
endmodule
